// >>> core/clock_startup_regs.vh
`ifndef CLOCK_STARTUP_REGS_VH
`define CLOCK_STARTUP_REGS_VH

// Clock source select codes (fuse value, 0 = programmed)
`define SRC_EXT_CLOCK       4'h0
`define SRC_RESERVED        4'h1
`define SRC_CAL_RC          4'h2
`define SRC_RC_128K         4'h3
`define SRC_LF_XTAL_LO      4'h4
`define SRC_FS_XTAL_LO      4'h6
`define SRC_LP_XTAL_LO      4'h8

// Source kind one-hot encoding
`define KIND_W              6
`define KIND_EXT            6'h01
`define KIND_CAL_RC         6'h02
`define KIND_RC_128K        6'h04
`define KIND_LF_XTAL        6'h08
`define KIND_FS_XTAL        6'h10
`define KIND_LP_XTAL        6'h20

// Low power crystal range codes
`define RANGE_0P4_0P9       3'h4
`define RANGE_0P9_3P0       3'h5
`define RANGE_3P0_8P0       3'h6
`define RANGE_8P0_16P0      3'h7

// Factory defaults
`define DEF_SOURCE_SELECT   4'h2
`define DEF_STARTUP_SELECT  2'h2
`define DEF_DIV8_FUSE       1'h0

// Time-out lengths in watchdog oscillator cycles
`define TOUT_W              14
`define TOUT_NONE           14'h0000
`define TOUT_SHORT          14'h0200
`define TOUT_LONG           14'h2000

// Oscillator start-up counts in oscillator cycles
`define OSC_W               16
`define OSC_6               16'h0006
`define OSC_14              16'h000E
`define OSC_258             16'h0102
`define OSC_1K              16'h0400
`define OSC_16K             16'h4000
`define OSC_32K             16'h8000

// System clock divide-by-eight terminal count
`define DIV8_LAST           3'h7

`endif

// >>> core/edge_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser with rising edge pulse on the second stage
module edge_sync (
    // Clock and reset
    input  wire ref_clk_in,
    input  wire rst_n_in,
    // Data
    input  wire async_in,
    output reg  level_out,
    output wire rise_out
);

    reg meta;
    reg prev;

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta      <= 1'b0;
            level_out <= 1'b0;
            prev      <= 1'b0;
        end else begin
            meta      <= async_in;
            level_out <= meta;
            prev      <= level_out;
        end
    end

    assign rise_out = level_out & ~prev;

endmodule

// >>> core/cycle_counter.v
`timescale 1ns/100ps
// Down counter advanced by an enable; done when a loaded count is used up
module cycle_counter #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             ref_clk_in,
    input  wire             rst_n_in,
    // Control
    input  wire             load_in,
    input  wire [WIDTH-1:0] count_in,
    input  wire             tick_in,
    output wire             done_out
);

    reg [WIDTH:0] remaining;

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remaining <= {(WIDTH+1){1'b0}};
        end else if (load_in) begin
            remaining <= {1'b0, count_in};
        end else if (tick_in && remaining != {(WIDTH+1){1'b0}}) begin
            remaining <= remaining - {{WIDTH{1'b0}}, 1'b1};
        end
    end

    assign done_out = (remaining == {(WIDTH+1){1'b0}}) & ~load_in;

endmodule

// >>> core/clock_startup_sequencer.v
// Contract
// - Codes 1111-1000 low power crystal, 0111-0110 full swing, 0101-0100 low frequency.
// - 0011 selects 128 kHz RC, 0010 calibrated RC, 0000 external; 0001 reserved.
// - A fuse reading 1 is unprogrammed, 0 is programmed.
// - Factory default is calibrated RC, start-up 10, divide-by-eight programmed.
// - Internal reset held for a time-out after other reset sources release.
// - Time-out counts 0, 512 or 8192 watchdog oscillator cycles.
// - Oscillator cycles counted before internal reset releases.
// - Reset start uses time-out then count; wake uses count only.
// - Start-up count ranges from 6 cycles external to 32K low frequency.
// - Low power crystal range from upper select bits 100,101,110,111.
// - Low power crystal group 0 start-up select mapping.
// - Low power crystal group 1 start-up select mapping.
// - Programmed divide-by-eight fuse divides system clock by eight; the code divides only for the calibrated RC and 128 kHz RC sources.
// - Factory trim loaded into oscillator trim register during reset.
`timescale 1ns/100ps
`include "clock_startup_regs.vh"
module clock_startup_sequencer #(
    parameter TRIM_W = 8
) (
    // Clock and reset
    input  wire              ref_clk_in,
    input  wire              rst_n_in,
    // Fuse store
    input  wire              fuses_valid_in,
    input  wire [3:0]        clock_source_select_in,
    input  wire [1:0]        startup_time_select_in,
    input  wire              divide_by_eight_fuse_in,
    input  wire              use_factory_default_in,
    input  wire [TRIM_W-1:0] factory_trim_in,
    // Reset sources and wake
    input  wire              ext_reset_active_in,
    input  wire              wake_request_in,
    // Oscillator clocks sampled as levels
    input  wire              watchdog_osc_in,
    input  wire              selected_osc_in,
    // Oscillator control
    output reg  [`KIND_W-1:0] oscillator_enable_out,
    output reg  [2:0]        oscillator_range_select_out,
    output reg               source_invalid_out,
    output reg  [TRIM_W-1:0] oscillator_trim_register_out,
    // Core side
    output reg               internal_reset_out,
    output reg               system_clock_enable_out,
    output reg               fuses_latched_out
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    wire fuses_valid_s;
    wire ext_reset_s;
    wire wake_rise;
    wire wdt_rise;
    wire osc_rise;

    edge_sync u_sync_valid (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(fuses_valid_in),
                            .level_out(fuses_valid_s), .rise_out());
    edge_sync u_sync_rst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(ext_reset_active_in),
                          .level_out(ext_reset_s), .rise_out());
    edge_sync u_sync_wake (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(wake_request_in),
                           .level_out(), .rise_out(wake_rise));
    edge_sync u_sync_wdt (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(watchdog_osc_in),
                          .level_out(), .rise_out(wdt_rise));
    edge_sync u_sync_osc (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .async_in(selected_osc_in),
                          .level_out(), .rise_out(osc_rise));

    // Fuse fields: two stages, settled long before the synced valid
    reg [3:0] src_meta;
    reg [3:0] src_sync;
    reg [1:0] sut_meta;
    reg [1:0] sut_sync;
    reg       div8_meta;
    reg       div8_sync;
    reg       dflt_meta;
    reg       dflt_sync;

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_meta  <= `DEF_SOURCE_SELECT;
            src_sync  <= `DEF_SOURCE_SELECT;
            sut_meta  <= `DEF_STARTUP_SELECT;
            sut_sync  <= `DEF_STARTUP_SELECT;
            div8_meta <= `DEF_DIV8_FUSE;
            div8_sync <= `DEF_DIV8_FUSE;
            dflt_meta <= 1'b0;
            dflt_sync <= 1'b0;
        end else begin
            src_meta  <= clock_source_select_in;
            src_sync  <= src_meta;
            sut_meta  <= startup_time_select_in;
            sut_sync  <= sut_meta;
            div8_meta <= divide_by_eight_fuse_in;
            div8_sync <= div8_meta;
            dflt_meta <= use_factory_default_in;
            dflt_sync <= dflt_meta;
        end
    end

    // ------------------------------------------------------------
    // Fuse capture
    // ------------------------------------------------------------
    reg [3:0] source_select;
    reg [1:0] startup_select;
    reg       div8_fuse;

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            source_select     <= `DEF_SOURCE_SELECT;
            startup_select    <= `DEF_STARTUP_SELECT;
            div8_fuse         <= `DEF_DIV8_FUSE;
            fuses_latched_out <= 1'b0;
        end else if (fuses_valid_s && !fuses_latched_out) begin
            fuses_latched_out <= 1'b1;
            if (!dflt_sync) begin
                source_select  <= src_sync;
                startup_select <= sut_sync;
                div8_fuse      <= div8_sync;
            end
        end
    end

    // ------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------
    function [`KIND_W-1:0] decode_source;
        input [3:0] sel;
        begin
            if (sel >= `SRC_LP_XTAL_LO)
                decode_source = `KIND_LP_XTAL;
            else if (sel >= `SRC_FS_XTAL_LO)
                decode_source = `KIND_FS_XTAL;
            else if (sel >= `SRC_LF_XTAL_LO)
                decode_source = `KIND_LF_XTAL;
            else if (sel == `SRC_RC_128K)
                decode_source = `KIND_RC_128K;
            else if (sel == `SRC_CAL_RC)
                decode_source = `KIND_CAL_RC;
            else if (sel == `SRC_EXT_CLOCK)
                decode_source = `KIND_EXT;
            else
                decode_source = {`KIND_W{1'b0}};
        end
    endfunction

    // Time-out length from the start-up select outside the low power crystal table
    function [`TOUT_W-1:0] sut_timeout;
        input [1:0] sut;
        begin
            if (sut == 2'h0)
                sut_timeout = `TOUT_NONE;
            else if (sut == 2'h1)
                sut_timeout = `TOUT_SHORT;
            else
                sut_timeout = `TOUT_LONG;
        end
    endfunction

    wire [`KIND_W-1:0] kind = decode_source(source_select);

    // ------------------------------------------------------------
    // Start-up tables
    // ------------------------------------------------------------
    // Time-out and oscillator count for the selected source and start-up select
    reg [`TOUT_W-1:0] tout_len;
    reg [`OSC_W-1:0]  osc_len;

    always @* begin
        tout_len = `TOUT_NONE;
        osc_len  = `OSC_6;
        case (kind)
            `KIND_LP_XTAL: begin
                case ({source_select[0], startup_select})
                    3'h0: begin osc_len = `OSC_258; tout_len = `TOUT_SHORT; end
                    3'h1: begin osc_len = `OSC_258; tout_len = `TOUT_LONG;  end
                    3'h2: begin osc_len = `OSC_1K;  tout_len = `TOUT_NONE;  end
                    3'h3: begin osc_len = `OSC_1K;  tout_len = `TOUT_SHORT; end
                    3'h4: begin osc_len = `OSC_1K;  tout_len = `TOUT_LONG;  end
                    3'h5: begin osc_len = `OSC_16K; tout_len = `TOUT_NONE;  end
                    3'h6: begin osc_len = `OSC_16K; tout_len = `TOUT_SHORT; end
                    default: begin osc_len = `OSC_16K; tout_len = `TOUT_LONG; end
                endcase
            end
            `KIND_FS_XTAL: begin
                osc_len = source_select[0] ? `OSC_16K : `OSC_258;
                tout_len = sut_timeout(startup_select);
            end
            `KIND_LF_XTAL: begin
                osc_len = source_select[0] ? `OSC_32K : `OSC_1K;
                tout_len = sut_timeout(startup_select);
            end
            default: begin
                // RC and external sources use 6 cycles
                osc_len = `OSC_6;
                tout_len = sut_timeout(startup_select);
            end
        endcase
    end

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    localparam ST_FUSE    = 5'h01;
    localparam ST_HOLD    = 5'h02;
    localparam ST_TIMEOUT = 5'h04;
    localparam ST_OSC     = 5'h08;
    localparam ST_RUN     = 5'h10;

    reg [4:0] state;
    reg [4:0] next_state;
    reg       load_tout;
    reg       load_osc;
    wire      tout_done;
    wire      osc_done;

    cycle_counter #(.WIDTH(`TOUT_W)) u_tout (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .load_in    (load_tout),
        .count_in   (tout_len),
        .tick_in    (wdt_rise),
        .done_out   (tout_done)
    );

    cycle_counter #(.WIDTH(`OSC_W)) u_osc (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .load_in    (load_osc),
        .count_in   (osc_len),
        .tick_in    (osc_rise),
        .done_out   (osc_done)
    );

    always @* begin
        next_state = state;
        load_tout  = 1'b0;
        load_osc   = 1'b0;
        case (state)
            ST_FUSE: begin
                if (fuses_latched_out)
                    next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (!ext_reset_s && kind != {`KIND_W{1'b0}}) begin
                    load_tout  = 1'b1;
                    next_state = ST_TIMEOUT;
                end
            end
            ST_TIMEOUT: begin
                if (ext_reset_s) begin
                    next_state = ST_HOLD;
                end else if (tout_done) begin
                    load_osc   = 1'b1;
                    next_state = ST_OSC;
                end
            end
            ST_OSC: begin
                if (ext_reset_s)
                    next_state = ST_HOLD;
                else if (osc_done)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (ext_reset_s) begin
                    next_state = ST_HOLD;
                end else if (wake_rise) begin
                    load_osc   = 1'b1;
                    next_state = ST_OSC;
                end
            end
            default: next_state = ST_FUSE;
        endcase
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            state <= ST_FUSE;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // System clock divider
    // ------------------------------------------------------------
    reg [2:0] div_count;
    wire      is_internal = (kind == `KIND_CAL_RC) | (kind == `KIND_RC_128K);
    wire      div_active  = ~div8_fuse & is_internal;

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            div_count <= 3'h0;
        else if (state != ST_RUN)
            div_count <= 3'h0;
        else if (osc_rise)
            div_count <= div_count + 3'h1;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            internal_reset_out           <= 1'b1;
            system_clock_enable_out      <= 1'b0;
            oscillator_enable_out        <= {`KIND_W{1'b0}};
            oscillator_range_select_out  <= 3'h0;
            source_invalid_out           <= 1'b0;
            oscillator_trim_register_out <= {TRIM_W{1'b0}};
        end else begin
            internal_reset_out      <= (next_state != ST_RUN) & (state != ST_RUN || ext_reset_s);
            system_clock_enable_out <= (state == ST_RUN) & osc_rise &
                                       (~div_active | (div_count == `DIV8_LAST));
            oscillator_enable_out   <= fuses_latched_out ? kind : {`KIND_W{1'b0}};
            source_invalid_out      <= fuses_latched_out & (kind == {`KIND_W{1'b0}});
            oscillator_range_select_out <= (kind == `KIND_LP_XTAL) ? source_select[3:1] : 3'h0;
            if (state != ST_RUN)
                oscillator_trim_register_out <= factory_trim_in;
        end
    end

endmodule

// >>> testbench/clock_startup_properties.sv
`timescale 1ns/100ps
`include "clock_startup_regs.vh"
module clock_startup_properties #(
    parameter TRIM_W = 8
) (
    input wire              ref_clk_in,
    input wire              rst_n_in,
    input wire              divide_by_eight_fuse_in,
    input wire              use_factory_default_in,
    input wire [TRIM_W-1:0] factory_trim_in,
    input wire              ext_reset_active_in,
    input wire              wake_request_in,
    input wire [5:0]        oscillator_enable_out,
    input wire [2:0]        oscillator_range_select_out,
    input wire              source_invalid_out,
    input wire [TRIM_W-1:0] oscillator_trim_register_out,
    input wire              internal_reset_out,
    input wire              system_clock_enable_out,
    input wire              fuses_latched_out
);
    // ----------------
    // Properties
    // ----------------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire div_on = (oscillator_enable_out == `KIND_CAL_RC || oscillator_enable_out == `KIND_RC_128K)
                  && (!divide_by_eight_fuse_in || use_factory_default_in);
    sequence s_tick;
        div_on && system_clock_enable_out;
    endsequence
    sequence s_ext_rise;
        $rose(ext_reset_active_in) && fuses_latched_out;
    endsequence
    a_unlatched_held: assert property (!fuses_latched_out |-> internal_reset_out && oscillator_enable_out == 6'h00)
        else $error("source enabled before fuses latched");
    a_reserved_held: assert property (source_invalid_out |-> internal_reset_out && oscillator_enable_out == 6'h00)
        else $error("reserved code left reset");
    a_source_onehot: assert property ($onehot0(oscillator_enable_out))
        else $error("more than one source enabled");
    a_invalid_exclusive: assert property ($past(fuses_latched_out) && fuses_latched_out |->
        source_invalid_out != (oscillator_enable_out != 6'h00))
        else $error("invalid flag disagrees with source");
    a_range_lp_only: assert property ((oscillator_enable_out == `KIND_LP_XTAL) ?
        oscillator_range_select_out[2] : oscillator_range_select_out == 3'h0)
        else $error("range select wrong for source");
    a_fuses_stable: assert property (fuses_latched_out && $past(fuses_latched_out, 2) |->
        $stable(oscillator_enable_out) && $stable(oscillator_range_select_out))
        else $error("source changed after latch");
    a_trim_follow: assert property (fuses_latched_out && internal_reset_out && $past(internal_reset_out)
        && $stable(factory_trim_in) |-> oscillator_trim_register_out == factory_trim_in)
        else $error("trim not loaded in reset");
    a_trim_frozen: assert property (!internal_reset_out && !$past(internal_reset_out) |->
        $stable(oscillator_trim_register_out))
        else $error("trim moved while running");
    a_quiet_in_reset: assert property (internal_reset_out && $past(internal_reset_out) |->
        !system_clock_enable_out)
        else $error("system clock ticked in reset");
    a_div_spacing: assert property (s_tick |=> !system_clock_enable_out [*8])
        else $error("divided clock ticks too close");
    a_ext_restart: assert property (s_ext_rise |-> ##[1:6] internal_reset_out)
        else $error("reset source did not restart hold");
    a_wake_restart: assert property ($rose(wake_request_in) && !internal_reset_out |->
        ##[1:8] internal_reset_out)
        else $error("wake did not hold core");
endmodule
bind clock_startup_sequencer clock_startup_properties #(.TRIM_W(TRIM_W)) props_inst (
    .ref_clk_in, .rst_n_in, .divide_by_eight_fuse_in, .use_factory_default_in, .factory_trim_in,
    .ext_reset_active_in, .wake_request_in, .oscillator_enable_out, .oscillator_range_select_out,
    .source_invalid_out, .oscillator_trim_register_out, .internal_reset_out,
    .system_clock_enable_out, .fuses_latched_out);

// >>> testbench/oscillator_model.sv
`timescale 1ns/100ps
module oscillator_model (
    input  wire       ref_clk_in,
    input  wire [5:0] oscillator_enable_in,
    output reg        watchdog_osc_out,
    output reg        selected_osc_out
);
    reg [1:0] phase = 2'h0;
    initial watchdog_osc_out = 1'b0;
    initial selected_osc_out = 1'b0;
    // Both at a quarter of the reference; chosen one still while disabled
    always @(posedge ref_clk_in) begin
        phase <= #1 phase + 2'h1;
        watchdog_osc_out <= #1 phase[1];
        selected_osc_out <= #1 phase[1] & (oscillator_enable_in != 6'h00);
    end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`include "clock_startup_regs.vh"
module testbench;
    reg        ref_clk_in;
    reg        rst_n_in = 1'b0;
    reg        fuses_valid_in = 1'b0;
    reg  [3:0] source_sel = 4'h0;
    reg  [1:0] startup_sel = 2'h0;
    reg        div_fuse = 1'b1;
    reg        use_default = 1'b0;
    reg  [7:0] trim = 8'h5A;
    reg        ext_reset = 1'b1;
    reg        wake = 1'b0;
    wire       wdt_osc;
    wire       sel_osc;
    wire [5:0] osc_en;
    wire [2:0] range;
    wire       invalid;
    wire [7:0] trim_reg;
    wire       int_rst;
    wire       sys_en;
    wire       latched;
    integer    n_fail = 0;
    integer    total_checks = 0;
    integer    cyc;
    integer    i;
    clock_startup_sequencer clock_startup_sequencer_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .fuses_valid_in(fuses_valid_in), .clock_source_select_in(source_sel), .startup_time_select_in(startup_sel),
        .divide_by_eight_fuse_in(div_fuse), .use_factory_default_in(use_default), .factory_trim_in(trim),
        .ext_reset_active_in(ext_reset), .wake_request_in(wake), .watchdog_osc_in(wdt_osc),
        .selected_osc_in(sel_osc), .oscillator_enable_out(osc_en), .oscillator_range_select_out(range),
        .source_invalid_out(invalid), .oscillator_trim_register_out(trim_reg), .internal_reset_out(int_rst),
        .system_clock_enable_out(sys_en), .fuses_latched_out(latched));
    oscillator_model oscillator_model_inst (.ref_clk_in(ref_clk_in), .oscillator_enable_in(osc_en),
        .watchdog_osc_out(wdt_osc), .selected_osc_out(sel_osc));
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // ----------------
    // Tasks
    // ----------------
    task print_verdict;
        begin
            $display("checks %0d failures %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task check_val(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task check_range(input integer v, input integer lo, input integer hi);
        begin
            total_checks = total_checks + 1;
            if (v >= lo && v <= hi) ;
            else begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h expected %h to %h", $time, v, lo, hi);
            end
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge ref_clk_in);
            #1;
        end
    endtask
    task wait_rst(input v, input integer bound);
        begin
            cyc = 0;
            while (int_rst !== v && cyc < bound) begin
                step(1);
                cyc = cyc + 1;
            end
            if (int_rst !== v) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h expected %h", $time, int_rst, v);
                print_verdict;
            end
        end
    endtask
    task boot(input [3:0] c, input [1:0] s, input d, input f);
        begin
            rst_n_in = 1'b0;
            fuses_valid_in = 1'b0;
            ext_reset = 1'b1;
            source_sel = c;
            startup_sel = s;
            div_fuse = d;
            use_default = f;
            step(12);
            rst_n_in = 1'b1;
            step(2);
            fuses_valid_in = 1'b1;
            step(6);
        end
    endtask
    task timed(input [3:0] c, input [1:0] s, input d, input f, input integer edges);
        begin
            boot(c, s, d, f);
            ext_reset = 1'b0;
            wait_rst(1'b0, edges * 4 + 40);
            check_range(cyc, edges * 4 - 4, edges * 4 + 16);
        end
    endtask
    task count_ticks(input integer lo, input integer hi);
        integer k;
        integer cnt;
        begin
            cnt = 0;
            for (k = 0; k < 320; k = k + 1) begin
                step(1);
                cnt = cnt + sys_en;
            end
            check_range(cnt, lo, hi);
        end
    endtask
    function [5:0] exp_kind(input [3:0] c);
        casez (c)
            4'b1???: exp_kind = `KIND_LP_XTAL;
            4'b011?: exp_kind = `KIND_FS_XTAL;
            4'b010?: exp_kind = `KIND_LF_XTAL;
            4'h3:    exp_kind = `KIND_RC_128K;
            4'h2:    exp_kind = `KIND_CAL_RC;
            4'h0:    exp_kind = `KIND_EXT;
            default: exp_kind = 6'h00;
        endcase
    endfunction
    // ----------------
    // Sequence
    // ----------------
    initial begin
        for (i = 0; i < 16; i = i + 1) begin
            boot(i[3:0], 2'h0, 1'b1, 1'b0);
            check_val(16'(osc_en), 16'(exp_kind(i[3:0])));
            check_val(16'(range), i[3] ? 16'(i[3:1]) : 16'h0000);
            check_val(16'(invalid), 16'(i == 1));
            check_val(16'(trim_reg), 16'(trim));
            check_val(16'(latched), 16'h0001);
        end
        boot(4'h1, 2'h0, 1'b1, 1'b0);
        ext_reset = 1'b0;
        step(100);
        check_val(16'(int_rst), 16'h0001);
        timed(4'h2, 2'h0, 1'b1, 1'b0, 6);
        count_ticks(79, 81);
        timed(4'hF, 2'h0, 1'b1, 1'b1, 8198);
        count_ticks(9, 11);
        timed(4'h8, 2'h0, 1'b1, 1'b0, 770);
        timed(4'h8, 2'h2, 1'b1, 1'b0, 1024);
        timed(4'h9, 2'h0, 1'b1, 1'b0, 9216);
        timed(4'h3, 2'h0, 1'b1, 1'b0, 6);
        timed(4'h6, 2'h0, 1'b1, 1'b0, 258);
        timed(4'h4, 2'h0, 1'b1, 1'b0, 1024);
        timed(4'h0, 2'h1, 1'b1, 1'b0, 518);
        trim = 8'hA5;
        step(5);
        check_val(16'(trim_reg), 16'h005A);
        trim = 8'h5A;
        source_sel = 4'hA;
        step(10);
        check_val(16'(osc_en), 16'(`KIND_EXT));
        wake = 1'b1;
        step(3);
        wake = 1'b0;
        wait_rst(1'b1, 20);
        wait_rst(1'b0, 60);
        check_range(cyc, 20, 40);
        ext_reset = 1'b1;
        wait_rst(1'b1, 10);
        check_val(16'(int_rst), 16'h0001);
        print_verdict;
    end
endmodule
